// ==== alu_pkg.sv ====
// Purpose: shared constants and types for the negate/abs/round/subtract datapath
// Assumes: 24-bit general registers, octal opcodes given here in hex
// Notes: register index order matches the one-hot select bit order
package alu_pkg;

  // ==========================================================
  // widths and register indices
  localparam int WORD_W = 24;
  localparam int REG_COUNT = 6;
  localparam int SEL_W = 6;
  localparam int DBL_W = 47;
  localparam int IDX_I = 0;
  localparam int IDX_J = 1;
  localparam int IDX_K = 2;
  localparam int IDX_E = 3;
  localparam int IDX_A = 4;
  localparam int IDX_T = 5;

  // ==========================================================
  // instruction fields
  localparam int OP12_HI = 23;
  localparam int OP12_LO = 12;
  localparam int OP6_HI = 23;
  localparam int OP6_LO = 18;
  localparam int FIELD_HI = 17;
  localparam int FIELD_LO = 15;
  localparam int SRC_HI = 11;
  localparam int SRC_LO = 6;
  localparam int DST_HI = 5;
  localparam int DST_LO = 0;

  // ==========================================================
  // opcodes
  localparam logic [11:0] OPC_BYTE_NEGATE = 12'h005;
  localparam logic [11:0] OPC_BYTE_ABSOLUTE = 12'h006;
  localparam logic [11:0] OPC_REG_NEGATE = 12'h012;
  localparam logic [11:0] OPC_REG_ABSOLUTE = 12'h013;
  localparam logic [11:0] OPC_SIGN_INVERT = 12'h01A;
  localparam logic [11:0] OPC_DOUBLE_NEGATE = 12'h01B;
  localparam logic [11:0] OPC_DOUBLE_ABSOLUTE = 12'h01C;
  localparam logic [11:0] OPC_ROUND = 12'h03D;
  localparam logic [5:0] OPC_MULTIPLY_BY_REGISTER = 6'h30;
  localparam logic [5:0] OPC_SUBTRACT_MEMORY_FROM_INDEX = 6'h29;

  // ==========================================================
  // values and reset values
  localparam logic [23:0] WORD_FULL_NEG = 24'h80_0000;
  localparam logic [7:0] BYTE_FULL_NEG = 8'h80;
  localparam logic [23:0] REG_RESET = 24'h00_0000;
  localparam logic [23:0] INSTR_RESET = 24'h00_0000;
  localparam int ROUND_BIT = 22;

  // ==========================================================
  // execution timing in clock cycles
  localparam logic [1:0] SINGLE_EXEC_CYCLES = 2'd1;
  localparam logic [1:0] MULTI_EXEC_CYCLES = 2'd2;

  // ==========================================================
  // types
  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_FETCH = 2'b01,
    ST_EXEC = 2'b10,
    ST_SETTLE = 2'b11
  } state_t;

  typedef enum logic [3:0] {
    K_NONE = 4'b0000,
    K_BYTE_NEG = 4'b0001,
    K_BYTE_ABS = 4'b0010,
    K_REG_NEG = 4'b0011,
    K_REG_ABS = 4'b0100,
    K_SIGN_INV = 4'b0101,
    K_DBL_NEG = 4'b0110,
    K_DBL_ABS = 4'b0111,
    K_ROUND = 4'b1000,
    K_MULTIPLY = 4'b1001,
    K_SUB_MEM = 4'b1010
  } op_kind_t;

endpackage

// ==== gp_register_file.sv ====
// Purpose: six general registers with per-register write enables
// Assumes: one write data word per register, all writes in one cycle
// Notes: read data come straight from the storage flops
`timescale 1ns/1ps
`default_nettype none
module gp_register_file #(
  parameter int WIDTH = alu_pkg::WORD_W,
  parameter int COUNT = alu_pkg::REG_COUNT
) (
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic ce,
  input wire logic [COUNT-1:0] wr_en,
  input wire logic [COUNT-1:0][WIDTH-1:0] wr_data,
  output logic [COUNT-1:0][WIDTH-1:0] rd_data
);
  import alu_pkg::*;

  // ==========================================================
  // elaboration checks
  initial begin
    if (WIDTH != WORD_W) $error("register width must match the datapath");
    if (COUNT < 1) $error("register count must be positive");
  end

  // ==========================================================
  // storage, one flop word per register
  genvar g;
  generate
    for (g = 0; g < COUNT; g++) begin : g_reg
      always_ff @(posedge sys_clk) begin
        if (rst) begin
          rd_data[g] <= REG_RESET;
        end else if (ce && wr_en[g]) begin
          rd_data[g] <= wr_data[g];
        end
      end
    end
  endgenerate
endmodule // gp_register_file
`default_nettype wire

// ==== mem_model.sv ====
// Purpose: memory operand responder for subtract-memory
// Assumes: answers after a set wait, ack held one sampling edge
// Notes: data line shows inverse of last word when idle
`timescale 1ns/1ps
`default_nettype none
module mem_model (
  input wire logic sys_clk,
  input wire logic mem_req,
  input wire logic mem_index_allowed,
  input wire logic [3:0] wait_cyc,
  input wire logic [23:0] word,
  output logic mem_ack,
  output logic [23:0] mem_data,
  output logic idx_seen
);
  logic [3:0] cnt;
  initial begin
    mem_ack = 1'b0;
    mem_data = 24'h00_0000;
    idx_seen = 1'b0;
    cnt = 4'h0;
  end
  // ==========================================================
  // answer after wait, release after sampled edge
  always @(posedge sys_clk) begin
    if (mem_ack) begin
      mem_ack <= 1'b0;
      mem_data <= ~mem_data;
      idx_seen <= mem_index_allowed;
      cnt <= 4'h0;
    end else if (mem_req && cnt == wait_cyc) begin
      mem_ack <= 1'b1;
      mem_data <= word;
    end else if (mem_req) begin
      cnt <= cnt + 4'h1;
    end
  end
endmodule // mem_model
`default_nettype wire

// ==== negate_abs_round_subtract_alu.sv ====
// Purpose: negate, absolute, sign invert, round, multiply-by-register, subtract memory
// Assumes: decoder gives one instruction word per start pulse; memory answers with ack
// Notes: condition flags and overflow leave as registered levels
//
// What this block does
// - multiply register field 1..6 selects I, J, K, E, A, T
// - multiply overflows when both operands and product are full-scale negative
// - byte negate writes two's complement of low eight bits of A, upper bits kept
// - byte negate overflows on the full-scale negative byte
// - byte negate and byte absolute set flags from the byte result
// - register negate writes two's complement of source, sets flags
// - source and destination selects are six one-hot bits I..T
// - multiple sources are ORed; result goes to every selected destination
// - register negate changes only selected destinations and flags
// - word negate overflows on the full-scale negative word
// - selecting T gives multiple-register execution timing
// - double negate negates E:A in place, overflow on full-scale negative double
// - byte absolute replaces low byte with its magnitude, overflow on full-scale
// - sign invert flips only the sign bit and updates flags
// - sign invert overflows when the operand is zero
// - double absolute puts magnitude of E:A into E:A, overflow on full-scale
// - register absolute writes magnitude of merged source, overflow on full-scale
// - round writes source plus one when A bit 22 set, else source
// - round leaves the source alone unless it is also a destination
// - round overflow when carry into sign differs from carry out
// - subtract memory from index I, J or K, result back to that index
// - first memory reference is not indexed, indirect reference may be
// - double value is E high word and A low word
// - registers are 24 bits, bit 23 the sign
`timescale 1ns/1ps
`default_nettype none
module negate_abs_round_subtract_alu #(
  parameter int WIDTH = alu_pkg::WORD_W
) (
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic ce,
  input wire logic start,
  input wire logic [alu_pkg::WORD_W-1:0] instr,
  input wire logic instr_indirect,
  input wire logic mem_ack,
  input wire logic [alu_pkg::WORD_W-1:0] mem_data,
  input wire logic load_en,
  input wire logic [alu_pkg::SEL_W-1:0] load_sel,
  input wire logic [alu_pkg::WORD_W-1:0] load_data,
  input wire logic ovf_clear,
  output logic busy,
  output logic done,
  output logic op_error,
  output logic mem_req,
  output logic mem_index_allowed,
  output logic cond_pos,
  output logic cond_neg,
  output logic cond_zero,
  output logic cond_ovf,
  output logic [alu_pkg::REG_COUNT-1:0][alu_pkg::WORD_W-1:0] regs
);
  import alu_pkg::*;

  // ==========================================================
  // elaboration checks
  initial begin
    if (WIDTH != WORD_W) $error("datapath width is fixed at 24 bits");
  end

  // ==========================================================
  // state
  state_t state;
  logic [WORD_W-1:0] ireg;
  logic [WORD_W-1:0] mem_word;
  logic [1:0] cycle_cnt;
  logic [SEL_W-1:0] res_sel;
  logic [WORD_W-1:0] res_word;
  logic [WORD_W-1:0] res_e;
  logic [WORD_W-1:0] res_a;
  logic res_neg;
  logic res_zero;
  logic res_ovf;
  logic res_err;

  // ==========================================================
  // field decode of the held instruction
  wire [11:0] op12 = ireg[OP12_HI:OP12_LO];
  wire [5:0] op6 = ireg[OP6_HI:OP6_LO];
  wire [2:0] rfield = ireg[FIELD_HI:FIELD_LO];
  wire [SEL_W-1:0] src_sel = ireg[SRC_HI:SRC_LO];
  wire [SEL_W-1:0] dst_sel = ireg[DST_HI:DST_LO];
  wire field_ok = (rfield >= 3'd1) && (rfield <= 3'd6);
  wire index_ok = (rfield >= 3'd1) && (rfield <= 3'd3);
  wire [SEL_W-1:0] field_sel = field_ok ? SEL_W'(6'h01 << (rfield - 3'd1)) : '0;

  // opcode classification
  wire is_short = (op6 == 6'h00);
  op_kind_t kind;
  assign kind = op_kind_t'(
    (is_short && op12 == OPC_BYTE_NEGATE) ? K_BYTE_NEG :
    (is_short && op12 == OPC_BYTE_ABSOLUTE) ? K_BYTE_ABS :
    (is_short && op12 == OPC_REG_NEGATE) ? K_REG_NEG :
    (is_short && op12 == OPC_REG_ABSOLUTE) ? K_REG_ABS :
    (is_short && op12 == OPC_SIGN_INVERT) ? K_SIGN_INV :
    (is_short && op12 == OPC_DOUBLE_NEGATE) ? K_DBL_NEG :
    (is_short && op12 == OPC_DOUBLE_ABSOLUTE) ? K_DBL_ABS :
    (is_short && op12 == OPC_ROUND) ? K_ROUND :
    (op6 == OPC_MULTIPLY_BY_REGISTER && field_ok) ? K_MULTIPLY :
    (op6 == OPC_SUBTRACT_MEMORY_FROM_INDEX && index_ok) ? K_SUB_MEM : K_NONE);
  wire uses_select = (kind == K_REG_NEG) || (kind == K_REG_ABS) ||
                     (kind == K_SIGN_INV) || (kind == K_ROUND);

  // ==========================================================
  // operand selection: OR of all selected sources, zero when none
  logic [WORD_W-1:0] merged_src;
  logic [WORD_W-1:0] field_src;
  always_comb begin
    merged_src = '0;
    field_src = '0;
    for (int i = 0; i < REG_COUNT; i++) begin
      if (src_sel[i]) merged_src = merged_src | regs[i];
      if (field_sel[i]) field_src = field_src | regs[i];
    end
  end

  // ==========================================================
  // arithmetic terms
  wire [WORD_W-1:0] acc = regs[IDX_A];
  wire [7:0] byte_in = acc[7:0];
  wire [7:0] byte_neg = 8'(~byte_in + 8'h01);
  wire [7:0] byte_abs = byte_in[7] ? byte_neg : byte_in;
  wire byte_full = (byte_in == BYTE_FULL_NEG);
  wire [WORD_W-1:0] word_neg = WORD_W'(~merged_src + 24'h00_0001);
  wire [WORD_W-1:0] word_abs = merged_src[WORD_W-1] ? word_neg : merged_src;
  wire word_full = (merged_src == WORD_FULL_NEG);
  // double integer: E high, A low 23 bits, A sign bit carries no weight
  wire [DBL_W-1:0] dbl_in = {regs[IDX_E], acc[WORD_W-2:0]};
  wire [DBL_W-1:0] dbl_neg = DBL_W'(~dbl_in + 47'h0000_0000_0001);
  wire [DBL_W-1:0] dbl_abs = dbl_in[DBL_W-1] ? dbl_neg : dbl_in;
  wire dbl_full = (dbl_in == {1'b1, {(DBL_W-1){1'b0}}});
  // round: add bit 22 of A, overflow from carry into and out of the sign
  wire round_inc = acc[ROUND_BIT];
  wire [WORD_W-1:0] round_sum = merged_src + {{(WORD_W-1){1'b0}}, round_inc};
  wire [WORD_W-1:0] low_sum = {1'b0, merged_src[WORD_W-2:0]} +
                              {{(WORD_W-1){1'b0}}, round_inc};
  wire round_cin = low_sum[WORD_W-1];
  wire round_cout = merged_src[WORD_W-1] & round_cin;
  wire round_ovf = round_cin ^ round_cout;
  // subtract memory word from index, carry rule for overflow
  wire [WORD_W:0] sub_full = {1'b0, field_src} + {1'b0, ~mem_word} + 25'h000_0001;
  wire [WORD_W-1:0] sub_low = {1'b0, field_src[WORD_W-2:0]} +
                              {1'b0, ~mem_word[WORD_W-2:0]} + 24'h00_0001;
  wire sub_ovf = sub_low[WORD_W-1] ^ sub_full[WORD_W];
  // multiply A by the field register, product in double format
  wire signed [2*WORD_W-1:0] product = $signed(acc) * $signed(field_src);
  wire mul_ovf = (acc == WORD_FULL_NEG) && (field_src == WORD_FULL_NEG) &&
                 (product[DBL_W-1:WORD_W-1] == WORD_FULL_NEG);

  // timer in either select group takes the longer timing
  wire t_chosen = uses_select && (src_sel[IDX_T] || dst_sel[IDX_T]);
  wire [1:0] exec_cycles = t_chosen ? MULTI_EXEC_CYCLES : SINGLE_EXEC_CYCLES;

  // ==========================================================
  // result selection for each operation
  logic [SEL_W-1:0] next_sel;
  logic [WORD_W-1:0] next_word;
  logic [WORD_W-1:0] next_e;
  logic [WORD_W-1:0] next_a;
  logic next_neg;
  logic next_zero;
  logic next_ovf;
  logic next_err;
  always_comb begin
    next_sel = '0;
    next_word = '0;
    next_e = '0;
    next_a = '0;
    next_neg = 1'b0;
    next_zero = 1'b0;
    next_ovf = 1'b0;
    next_err = 1'b0;
    case (kind)
      K_BYTE_NEG, K_BYTE_ABS: begin
        next_word = {acc[WORD_W-1:8], (kind == K_BYTE_NEG) ? byte_neg : byte_abs};
        next_sel = SEL_W'(6'h01 << IDX_A);
        next_neg = next_word[7];
        next_zero = (next_word[7:0] == 8'h00);
        next_ovf = byte_full;
      end
      K_REG_NEG: begin
        next_word = word_neg;
        next_sel = dst_sel;
        next_ovf = word_full;
      end
      K_REG_ABS: begin
        next_word = word_abs;
        next_sel = dst_sel;
        next_ovf = word_full;
      end
      K_SIGN_INV: begin
        next_word = {~merged_src[WORD_W-1], merged_src[WORD_W-2:0]};
        next_sel = dst_sel;
        next_ovf = (merged_src == '0);
      end
      K_ROUND: begin
        next_word = round_sum;
        next_sel = dst_sel;
        next_ovf = round_ovf;
      end
      K_DBL_NEG, K_DBL_ABS: begin
        next_e = (kind == K_DBL_NEG) ? dbl_neg[DBL_W-1:WORD_W-1] :
                                       dbl_abs[DBL_W-1:WORD_W-1];
        next_a = {1'b0, (kind == K_DBL_NEG) ? dbl_neg[WORD_W-2:0] : dbl_abs[WORD_W-2:0]};
        next_sel = SEL_W'(6'h01 << IDX_E) | SEL_W'(6'h01 << IDX_A);
        next_neg = next_e[WORD_W-1];
        next_zero = (next_e == '0) && (next_a == '0);
        next_ovf = dbl_full;
      end
      K_MULTIPLY: begin
        next_e = product[DBL_W-1:WORD_W-1];
        next_a = {1'b0, product[WORD_W-2:0]};
        next_sel = SEL_W'(6'h01 << IDX_E) | SEL_W'(6'h01 << IDX_A);
        next_neg = next_e[WORD_W-1];
        next_zero = (next_e == '0) && (next_a == '0);
        next_ovf = mul_ovf;
      end
      K_SUB_MEM: begin
        next_word = sub_full[WORD_W-1:0];
        next_sel = field_sel;
        next_ovf = sub_ovf;
      end
      default: begin
        next_err = 1'b1;
      end
    endcase
    // single-word results take flags from the whole word
    if (kind != K_BYTE_NEG && kind != K_BYTE_ABS && kind != K_DBL_NEG &&
        kind != K_DBL_ABS && kind != K_MULTIPLY && kind != K_NONE) begin
      next_neg = next_word[WORD_W-1];
      next_zero = (next_word == '0);
    end
    if (kind != K_DBL_NEG && kind != K_DBL_ABS && kind != K_MULTIPLY) begin
      next_e = next_word;
      next_a = next_word;
    end
  end

  // ==========================================================
  // register file write path: commit or idle-time load
  wire commit = (state == ST_SETTLE) && (cycle_cnt == 2'd1);
  wire load_ok = (state == ST_IDLE) && load_en && !start;
  wire [REG_COUNT-1:0] wr_en = commit ? res_sel : (load_ok ? load_sel : '0);
  logic [REG_COUNT-1:0][WORD_W-1:0] wr_data;
  always_comb begin
    for (int i = 0; i < REG_COUNT; i++) begin
      if (!commit) wr_data[i] = load_data;
      else if (i == IDX_E) wr_data[i] = res_e;
      else if (i == IDX_A) wr_data[i] = res_a;
      else wr_data[i] = res_word;
    end
  end

  gp_register_file #(
    .WIDTH(WORD_W),
    .COUNT(REG_COUNT)
  ) u_regs (
    .sys_clk(sys_clk),
    .rst(rst),
    .ce(ce),
    .wr_en(wr_en),
    .wr_data(wr_data),
    .rd_data(regs)
  );

  // ==========================================================
  // sequencer
  wire sub_mem_start = (instr[OP6_HI:OP6_LO] == OPC_SUBTRACT_MEMORY_FROM_INDEX);
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      state <= ST_IDLE;
      ireg <= INSTR_RESET;
      mem_word <= '0;
      mem_req <= 1'b0;
      mem_index_allowed <= 1'b0;
      cycle_cnt <= 2'd0;
    end else if (ce) begin
      case (state)
        ST_IDLE: begin
          if (start) begin
            ireg <= instr;
            state <= sub_mem_start ? ST_FETCH : ST_EXEC;
            mem_req <= sub_mem_start;
            mem_index_allowed <= sub_mem_start && instr_indirect;
          end
        end
        ST_FETCH: begin
          if (mem_ack) begin
            mem_word <= mem_data;
            mem_req <= 1'b0;
            mem_index_allowed <= 1'b0;
            state <= ST_EXEC;
          end
        end
        ST_EXEC: begin
          cycle_cnt <= exec_cycles;
          state <= ST_SETTLE;
        end
        ST_SETTLE: begin
          if (cycle_cnt == 2'd1) state <= ST_IDLE;
          else cycle_cnt <= cycle_cnt - 2'd1;
        end
        default: state <= ST_IDLE;
      endcase
    end
  end

  // result capture at the execute step
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      res_sel <= '0;
      res_word <= '0;
      res_e <= '0;
      res_a <= '0;
      res_neg <= 1'b0;
      res_zero <= 1'b0;
      res_ovf <= 1'b0;
      res_err <= 1'b0;
    end else if (ce && state == ST_EXEC) begin
      res_sel <= next_err ? '0 : next_sel;
      res_word <= next_word;
      res_e <= next_e;
      res_a <= next_a;
      res_neg <= next_neg;
      res_zero <= next_zero;
      res_ovf <= next_ovf;
      res_err <= next_err;
    end
  end

  // ==========================================================
  // condition register and status; overflow set wins over clear
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      cond_pos <= 1'b0;
      cond_neg <= 1'b0;
      cond_zero <= 1'b0;
      cond_ovf <= 1'b0;
      done <= 1'b0;
      op_error <= 1'b0;
      busy <= 1'b0;
    end else if (ce) begin
      done <= commit;
      op_error <= commit && res_err;
      busy <= (state == ST_IDLE) ? start : !commit;
      if (commit && !res_err) begin
        cond_pos <= !res_neg && !res_zero;
        cond_neg <= res_neg;
        cond_zero <= res_zero;
      end
      if (commit && !res_err && res_ovf) cond_ovf <= 1'b1;
      else if (ovf_clear) cond_ovf <= 1'b0;
    end
  end
endmodule // negate_abs_round_subtract_alu
`default_nettype wire

// ==== negate_abs_round_subtract_alu_chk.sv ====
// Purpose: port-level assertions for the arithmetic datapath
// Assumes: single clock, synchronous active-high reset
// Notes: attached with bind after the module
`timescale 1ns/1ps
`default_nettype none
module negate_abs_round_subtract_alu_chk import alu_pkg::*; #(
  parameter int WIDTH = WORD_W
) (
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic ce,
  input wire logic start,
  input wire logic [WORD_W-1:0] instr,
  input wire logic mem_ack,
  input wire logic load_en,
  input wire logic ovf_clear,
  input wire logic busy,
  input wire logic done,
  input wire logic op_error,
  input wire logic mem_req,
  input wire logic cond_pos,
  input wire logic cond_neg,
  input wire logic cond_zero,
  input wire logic cond_ovf,
  input wire logic [REG_COUNT-1:0][WORD_W-1:0] regs
);
  // ==========================================================
  // sequences
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (rst);
  wire take = ce && start && !busy;
  wire short_op = instr[23:18] == 6'h00;
  wire uses_t = instr[11] || instr[5];
  sequence s_short_take;
    take && short_op && !uses_t;
  endsequence
  sequence s_timer_take;
    take && short_op && uses_t && instr[23:12] == OPC_REG_NEGATE;
  endsequence
  // ==========================================================
  // assertions
  AST_SHORT_TIME: assert property (s_short_take |-> ##1 !done [*2] ##1 done)
    else $error("short op done not after three cycles");
  AST_TIMER_TIME: assert property (s_timer_take |-> ##1 !done [*3] ##1 done)
    else $error("timer op done not after four cycles");
  AST_TAKE_BUSY: assert property (take |=> busy)
    else $error("busy not raised after start");
  AST_DONE_PULSE: assert property (done |-> !busy ##1 !done)
    else $error("done not a one-cycle pulse");
  AST_ERR_DONE: assert property (op_error |-> done)
    else $error("op_error without done");
  AST_FLAGS: assert property (done && !op_error |-> $onehot({cond_pos, cond_neg, cond_zero}))
    else $error("condition flags not exactly one");
  AST_OVF_STICKY: assert property (cond_ovf && !ovf_clear |=> cond_ovf)
    else $error("overflow lost without clear");
  AST_REGS_QUIET: assert property ($changed(regs) |-> done || $past(load_en))
    else $error("registers changed outside commit");
  AST_MEM_REQ: assert property (take && instr[23:18] == OPC_SUBTRACT_MEMORY_FROM_INDEX
    && instr[17:15] inside {3'd1, 3'd2, 3'd3} |=> mem_req)
    else $error("memory not requested");
  AST_MEM_DROP: assert property (mem_req && mem_ack && ce |=> !mem_req)
    else $error("mem_req held after ack");
endmodule // negate_abs_round_subtract_alu_chk
bind negate_abs_round_subtract_alu negate_abs_round_subtract_alu_chk #(.WIDTH(WIDTH)) u_chk (
  .sys_clk(sys_clk), .rst(rst), .ce(ce), .start(start), .instr(instr), .mem_ack(mem_ack),
  .load_en(load_en), .ovf_clear(ovf_clear), .busy(busy), .done(done), .op_error(op_error),
  .mem_req(mem_req), .cond_pos(cond_pos), .cond_neg(cond_neg), .cond_zero(cond_zero),
  .cond_ovf(cond_ovf), .regs(regs));
`default_nettype wire

// ==== negate_abs_round_subtract_alu_tb.sv ====
// Purpose: self-checking bench for the arithmetic datapath
// Assumes: 40 MHz clock, inputs changed at falling edge
// Notes: expectations worked out by hand from the operation rules
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, b) begin checked++; if ((a) !== (b)) begin n_fail++; \
  $display("unexpected at %0t: %h vs %h", $time, (a), (b)); end end
module negate_abs_round_subtract_alu_tb;
  import alu_pkg::*;
  logic sys_clk = 0, rst = 1, ce = 1, start = 0, instr_indirect = 0, load_en = 0, ovf_clear = 0;
  logic [23:0] instr = 24'h00_0000, load_data = 24'h00_0000, word = 24'h00_0000;
  logic [5:0] load_sel = 6'h00;
  logic [3:0] wait_cyc = 4'h2;
  logic busy, done, op_error, mem_req, mem_index_allowed, mem_ack, idx_seen;
  logic cond_pos, cond_neg, cond_zero, cond_ovf;
  logic [23:0] mem_data;
  logic [REG_COUNT-1:0][WORD_W-1:0] regs;
  int n_fail = 0, checked = 0, cyc;
  always #12.5 sys_clk = ~sys_clk;
  negate_abs_round_subtract_alu u_dut (.sys_clk(sys_clk), .rst(rst), .ce(ce),
    .start(start), .instr(instr), .instr_indirect(instr_indirect), .mem_ack(mem_ack),
    .mem_data(mem_data), .load_en(load_en), .load_sel(load_sel), .load_data(load_data),
    .ovf_clear(ovf_clear), .busy(busy), .done(done), .op_error(op_error), .mem_req(mem_req),
    .mem_index_allowed(mem_index_allowed), .cond_pos(cond_pos), .cond_neg(cond_neg),
    .cond_zero(cond_zero), .cond_ovf(cond_ovf), .regs(regs));
  mem_model u_mem (.sys_clk(sys_clk), .mem_req(mem_req), .mem_index_allowed(mem_index_allowed),
    .wait_cyc(wait_cyc), .word(word), .mem_ack(mem_ack), .mem_data(mem_data),
    .idx_seen(idx_seen));
  // ==========================================================
  // bus tasks
  task automatic ld(input logic [5:0] sel, input logic [23:0] d);
    @(negedge sys_clk);
    load_en = 1'b1;
    load_sel = sel;
    load_data = d;
    @(negedge sys_clk);
    load_en = 1'b0;
  endtask
  task automatic op(input logic [23:0] w, input logic ind);
    @(negedge sys_clk);
    start = 1'b1;
    instr = w;
    instr_indirect = ind;
    ovf_clear = 1'b1;
    @(negedge sys_clk);
    start = 1'b0;
    ovf_clear = 1'b0;
    cyc = 1;
    while (done !== 1'b1 && cyc < 40) begin
      @(negedge sys_clk);
      cyc++;
    end
    if (cyc >= 40) begin
      n_fail++;
      $display("unexpected at %0t: no done", $time);
    end
  endtask
  function automatic logic [23:0] sh(input logic [11:0] o, input logic [5:0] s, d);
    return {o, s, d};
  endfunction
  task automatic flags(input logic [2:0] pnz, input logic ovf);
    `CHK({cond_pos, cond_neg, cond_zero, cond_ovf}, {pnz, ovf})
  endtask
  // ==========================================================
  // scenarios
  task automatic t_byte;
    ld(6'h10, 24'h12_3401);
    op(sh(OPC_BYTE_NEGATE, 6'h00, 6'h00), 1'b0);
    `CHK(regs[IDX_A], 24'h12_34FF)
    flags(3'b010, 1'b0);
    `CHK(cyc, 3)
    ld(6'h10, 24'h55_5580);
    op(sh(OPC_BYTE_NEGATE, 6'h00, 6'h00), 1'b0);
    flags(3'b010, 1'b1);
    ld(6'h10, 24'hAB_00F0);
    op(sh(OPC_BYTE_ABSOLUTE, 6'h00, 6'h00), 1'b0);
    `CHK(regs[IDX_A], 24'hAB_0010)
    flags(3'b100, 1'b0);
  endtask
  task automatic t_reg;
    ld(6'h01, 24'h00_0005);
    ld(6'h02, 24'h00_0030);
    ld(6'h30, 24'h00_0777);
    op(sh(OPC_REG_NEGATE, 6'h03, 6'h0C), 1'b0);
    `CHK(regs[IDX_K], 24'hFF_FFCB)
    `CHK(regs[IDX_E], 24'hFF_FFCB)
    `CHK({regs[IDX_I], regs[IDX_A], regs[IDX_T]}, {24'h5, 24'h777, 24'h777})
    flags(3'b010, 1'b0);
    ld(6'h08, WORD_FULL_NEG);
    op(sh(OPC_REG_NEGATE, 6'h08, 6'h10), 1'b0);
    flags(3'b010, 1'b1);
    op(sh(OPC_REG_NEGATE, 6'h20, 6'h01), 1'b0);
    `CHK(regs[IDX_I], 24'hFF_F889)
    `CHK(cyc, 4)
    ld(6'h01, 24'hFF_FFFB);
    op(sh(OPC_REG_ABSOLUTE, 6'h01, 6'h02), 1'b0);
    `CHK(regs[IDX_J], 24'h00_0005)
    op(sh(OPC_REG_ABSOLUTE, 6'h08, 6'h04), 1'b0);
    flags(3'b010, 1'b1);
    op(sh(OPC_REG_ABSOLUTE, 6'h00, 6'h10), 1'b0);
    `CHK(regs[IDX_A], 24'h00_0000)
    flags(3'b001, 1'b0);
  endtask
  task automatic t_sign;
    ld(6'h01, 24'h00_0007);
    op(sh(OPC_SIGN_INVERT, 6'h01, 6'h01), 1'b0);
    `CHK(regs[IDX_I], 24'h80_0007)
    flags(3'b010, 1'b0);
    ld(6'h01, 24'h00_0000);
    op(sh(OPC_SIGN_INVERT, 6'h01, 6'h01), 1'b0);
    flags(3'b010, 1'b1);
    // frozen clock enable: a load must not land
    @(negedge sys_clk) ce = 1'b0;
    ld(6'h01, 24'h00_0001);
    ce = 1'b1;
    `CHK(regs[IDX_I], 24'h80_0000)
  endtask
  task automatic t_double;
    ld(6'h08, 24'h00_0000);
    ld(6'h10, 24'h00_0001);
    op(sh(OPC_DOUBLE_NEGATE, 6'h00, 6'h00), 1'b0);
    `CHK({regs[IDX_E], regs[IDX_A]}, {24'hFF_FFFF, 24'h7F_FFFF})
    op(sh(OPC_DOUBLE_ABSOLUTE, 6'h00, 6'h00), 1'b0);
    `CHK({regs[IDX_E], regs[IDX_A]}, {24'h00_0000, 24'h00_0001})
    flags(3'b100, 1'b0);
    ld(6'h08, WORD_FULL_NEG);
    ld(6'h10, 24'h00_0000);
    op(sh(OPC_DOUBLE_NEGATE, 6'h00, 6'h00), 1'b0);
    `CHK(cond_ovf, 1'b1)
    op(sh(OPC_DOUBLE_ABSOLUTE, 6'h00, 6'h00), 1'b0);
    `CHK(cond_ovf, 1'b1)
  endtask
  task automatic t_round;
    ld(6'h04, 24'h7F_FFFF);
    ld(6'h10, 24'h40_0000);
    op(sh(OPC_ROUND, 6'h04, 6'h02), 1'b0);
    `CHK(regs[IDX_J], 24'h80_0000)
    `CHK(regs[IDX_K], 24'h7F_FFFF)
    flags(3'b010, 1'b1);
    ld(6'h10, 24'h00_0000);
    op(sh(OPC_ROUND, 6'h04, 6'h02), 1'b0);
    `CHK(regs[IDX_J], 24'h7F_FFFF)
    flags(3'b100, 1'b0);
  endtask
  task automatic t_mul;
    ld(6'h08, 24'h00_0005);
    ld(6'h10, 24'h00_0003);
    op({OPC_MULTIPLY_BY_REGISTER, 3'd4, 15'h0000}, 1'b0);
    `CHK({regs[IDX_E], regs[IDX_A]}, {24'h00_0000, 24'h00_000F})
    ld(6'h10, WORD_FULL_NEG);
    op({OPC_MULTIPLY_BY_REGISTER, 3'd5, 15'h0000}, 1'b0);
    `CHK(cond_ovf, 1'b1)
    // field 7 is no register: error pulse, nothing written
    op({OPC_MULTIPLY_BY_REGISTER, 3'd7, 15'h0000}, 1'b0);
    `CHK({op_error, busy, regs[IDX_E]}, {2'b10, WORD_FULL_NEG})
  endtask
  task automatic t_mem;
    ld(6'h01, 24'h00_000A);
    word = 24'h00_0003;
    op({OPC_SUBTRACT_MEMORY_FROM_INDEX, 3'd1, 15'h0000}, 1'b1);
    `CHK(regs[IDX_I], 24'h00_0007)
    `CHK(idx_seen, 1'b1)
    ld(6'h04, 24'h00_0002);
    wait_cyc = 4'h0;
    op({OPC_SUBTRACT_MEMORY_FROM_INDEX, 3'd3, 15'h0000}, 1'b0);
    `CHK(regs[IDX_K], 24'hFF_FFFF)
    `CHK(idx_seen, 1'b0)
  endtask
  // ==========================================================
  // verdict, watchdog, main sequence
  task automatic give_verdict;
    $display("checked %0d, n_fail %0d", checked, n_fail);
    if (n_fail == 0 && checked > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask
  initial begin
    #(25 * 5000);
    n_fail++;
    give_verdict();
  end
  initial begin
    repeat (4) @(negedge sys_clk);
    rst = 1'b0;
    `CHK(regs, {REG_COUNT{REG_RESET}})
    t_byte();
    t_reg();
    t_sign();
    t_double();
    t_round();
    t_mul();
    t_mem();
    give_verdict();
  end
endmodule // negate_abs_round_subtract_alu_tb
`default_nettype wire
